// File: common/tvr_pkg.sv
package tvr_pkg;
    // register byte offsets from the module base
    localparam logic [15:0] OFS_STATUS = 16'h1002;
    localparam logic [15:0] OFS_RELOC_HI = 16'h1004;
    localparam logic [15:0] OFS_RELOC_LO = 16'h1006;
    localparam logic [15:0] OFS_RELOC_EN = 16'h1008;
    localparam logic [15:0] OFS_IRQ_LEVEL = 16'h100a;
    localparam logic [15:0] OFS_IRQ_VECTOR = 16'h100c;
    localparam logic [15:0] OFS_SLOT = 16'h100e;
    localparam logic [15:0] OFS_BCAST_BASE = 16'h1010;
    localparam logic [15:0] OFS_BCAST_CTL = 16'h1012;
    localparam logic [15:0] OFS_MOD_RESET = 16'h1014;
    localparam logic [15:0] OFS_SW_CLEAR = 16'h1016;
    localparam logic [15:0] OFS_SW_EVRESET = 16'h1018;
    localparam logic [15:0] OFS_SW_TRIG = 16'h101a;
    localparam logic [15:0] OFS_EVCOUNT = 16'h101c;
    localparam logic [15:0] OFS_EVSTORED = 16'h1020;
    localparam logic [15:0] OFS_AFL = 16'h1022;
    localparam logic [15:0] OFS_BLT_NUM = 16'h1024;
    localparam logic [15:0] OFS_FW_REV = 16'h1026;
    localparam logic [15:0] OFS_TEST_WORD = 16'h1028;
    localparam logic [15:0] OFS_OUT_SEL = 16'h102c;

    // reset values
    localparam logic [2:0] RST_IRQ_LEVEL = 3'h0;
    localparam logic [7:0] RST_IRQ_VECTOR = 8'hdd;
    localparam logic [4:0] RST_SLOT = 5'h1f;
    localparam logic [7:0] RST_BCAST_BASE = 8'haa;
    localparam logic [15:0] RST_AFL = 16'h0040;
    localparam logic [7:0] RST_BLT_NUM = 8'h00;
    // arbitrary neutral revision code
    localparam logic [7:0] FW_REVISION = 8'h10;

    // buffer sizing
    localparam logic [15:0] BUF_CAPACITY = 16'h8000;
    localparam logic [15:0] FULL_MARGIN = 16'h0021;
    localparam logic [15:0] FULL_LEVEL = BUF_CAPACITY - FULL_MARGIN;
    localparam logic [15:0] AFL_MIN = 16'h0001;
    localparam logic [15:0] AFL_MAX = 16'h7fdf;

    // status word bit positions
    localparam int ST_HAS_DATA = 0;
    localparam int ST_ALMOST = 1;
    localparam int ST_FULL = 2;
    localparam int ST_MODE = 3;
    localparam int ST_HDR = 4;
    localparam int ST_TERM = 5;
    localparam int ST_ERR = 6;
    localparam int ST_BERR = 10;
    localparam int ST_PURGED = 11;
    localparam int ST_RESOLUTION = 12;
    localparam int ST_PAIR = 14;
    localparam int ST_TLOST = 15;
    localparam int N_TDC = 4;

    // register access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [31:0] wdata;
    } tvr_req_t;

    // acquisition state reported by the rest of the module
    typedef struct packed {
        logic window_mode_flag;
        logic header_en;
        logic pair_mode;
        logic term_on;
        logic [1:0] resolution_code;
        logic [N_TDC-1:0] tdc_err;
    } tvr_acq_t;
endpackage

// File: rtl/tvr_reg_bank.sv
`timescale 1ns/100ps
// Summary of operation
// - data ready reflects buffer content per mode
// - almost full flag and interrupt request
// - full at capacity minus 33 words
// - status shows mode, headers, pair mode
// - two-bit resolution code in status
// - one sticky error bit per converter
// - bus fault flag, cleared by status read
// - drained bit, sent mark cleared at chain end
// - lost trigger flag, cleared by read
// - two relocation address byte registers
// - relocation enable selects base address
// - interrupt level, zero disables
// - vector driven during interrupt acknowledge
// - slot address resets to all ones
// - broadcast base address defaults 0xaa
// - any reset-location access resets module
// - clear empties buffer, zeroes counter
// - software trigger acts as external trigger
// - event counter counts in window mode
// - almost-full threshold 1..32735, default 64
// - block transfer event count, eight bits
// - test words pushed, converter data blocked
module tvr_reg_bank (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register access port
    input wire tvr_pkg::tvr_req_t req,
    input wire logic iack,
    output logic ack_q,
    output logic [31:0] rdata_q,
    // acquisition side
    input wire tvr_pkg::tvr_acq_t acq,
    input wire logic [15:0] buf_words,
    input wire logic event_in,
    input wire logic event_out,
    input wire logic ext_trigger,
    input wire logic trigger_dropped,
    input wire logic bus_fault,
    input wire logic chain_sent_all,
    input wire logic chain_end,
    input wire logic test_mode,
    input wire logic [15:0] switch_base,
    // control outputs
    output logic [15:0] base_addr_q,
    output logic [2:0] irq_level_q,
    output logic irq_req_q,
    output logic [4:0] slot_q,
    output logic [7:0] bcast_base_q,
    output logic [1:0] bcast_ctl_q,
    output logic [15:0] afl_q,
    output logic [7:0] blt_num_q,
    output logic [2:0] out_sel_q,
    output logic module_reset_q,
    output logic clear_q,
    output logic event_reset_q,
    output logic trigger_q,
    output logic test_push_q,
    output logic [31:0] test_word_q,
    output logic tdc_block_q
);
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] o);
        hit = (a == o);
    endfunction

    wire logic [15:0] a = req.addr;
    wire logic acc = req.rd | req.wr;
    wire logic w_rhi = req.wr & hit(a, tvr_pkg::OFS_RELOC_HI);
    wire logic w_rlo = req.wr & hit(a, tvr_pkg::OFS_RELOC_LO);
    wire logic w_ren = req.wr & hit(a, tvr_pkg::OFS_RELOC_EN);
    wire logic w_lvl = req.wr & hit(a, tvr_pkg::OFS_IRQ_LEVEL);
    wire logic w_vec = req.wr & hit(a, tvr_pkg::OFS_IRQ_VECTOR);
    wire logic w_slot = req.wr & hit(a, tvr_pkg::OFS_SLOT);
    wire logic w_bb = req.wr & hit(a, tvr_pkg::OFS_BCAST_BASE);
    wire logic w_bc = req.wr & hit(a, tvr_pkg::OFS_BCAST_CTL);
    wire logic w_clr = req.wr & hit(a, tvr_pkg::OFS_SW_CLEAR);
    wire logic w_evr = req.wr & hit(a, tvr_pkg::OFS_SW_EVRESET);
    wire logic w_trg = req.wr & hit(a, tvr_pkg::OFS_SW_TRIG);
    wire logic w_afl = req.wr & hit(a, tvr_pkg::OFS_AFL);
    wire logic w_blt = req.wr & hit(a, tvr_pkg::OFS_BLT_NUM);
    wire logic w_tst = req.wr & hit(a, tvr_pkg::OFS_TEST_WORD);
    wire logic w_out = req.wr & hit(a, tvr_pkg::OFS_OUT_SEL);
    wire logic r_st = req.rd & ~iack & hit(a, tvr_pkg::OFS_STATUS);
    wire logic a_rst = acc & hit(a, tvr_pkg::OFS_MOD_RESET);

    // soft reset: module reset location restores all state but test word, block flag and bus answer
    wire logic srst = reset | module_reset_q;

    // register state
    logic [7:0] rhi_q, rlo_q;
    logic reloc_q;
    logic [7:0] vec_q;
    localparam int N_ERR = tvr_pkg::N_TDC;
    logic [N_ERR-1:0] err_q;
    logic berr_q, tlost_q, sent_q;
    logic [31:0] evcnt_q;
    logic [15:0] evst_q;

    wire logic trig_any = ext_trigger | trigger_q;
    wire logic mode = acq.window_mode_flag;

    wire logic buffer_has_data_flag = mode ? (evst_q != 16'h0000)
                                           : (buf_words != 16'h0000);
    wire logic almost = buf_words >= afl_q;
    wire logic full = buf_words >= tvr_pkg::FULL_LEVEL;
    wire logic purged = (buf_words == 16'h0000) | sent_q;

    logic [15:0] status;
    always_comb begin
        status = 16'h0000;
        status[tvr_pkg::ST_HAS_DATA] = buffer_has_data_flag;
        status[tvr_pkg::ST_ALMOST] = almost;
        status[tvr_pkg::ST_FULL] = full;
        status[tvr_pkg::ST_MODE] = mode;
        status[tvr_pkg::ST_HDR] = acq.header_en;
        status[tvr_pkg::ST_PAIR] = acq.pair_mode;
        status[tvr_pkg::ST_TERM] = acq.term_on;
        status[tvr_pkg::ST_RESOLUTION +: 2] = acq.resolution_code;
        status[tvr_pkg::ST_ERR +: N_ERR] = err_q;
        status[tvr_pkg::ST_BERR] = berr_q;
        status[tvr_pkg::ST_PURGED] = purged;
        status[tvr_pkg::ST_TLOST] = tlost_q;
    end

    // read multiplexer
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        case (a)
            tvr_pkg::OFS_STATUS: rmux[15:0] = status;
            tvr_pkg::OFS_RELOC_HI: rmux[7:0] = rhi_q;
            tvr_pkg::OFS_RELOC_LO: rmux[7:0] = rlo_q;
            tvr_pkg::OFS_IRQ_LEVEL: rmux[2:0] = irq_level_q;
            tvr_pkg::OFS_IRQ_VECTOR: rmux[7:0] = vec_q;
            tvr_pkg::OFS_SLOT: rmux[4:0] = slot_q;
            tvr_pkg::OFS_BCAST_BASE: rmux[7:0] = bcast_base_q;
            tvr_pkg::OFS_BCAST_CTL: rmux[1:0] = bcast_ctl_q;
            tvr_pkg::OFS_EVCOUNT: rmux = evcnt_q;
            tvr_pkg::OFS_EVSTORED: rmux[15:0] = evst_q;
            tvr_pkg::OFS_AFL: rmux[15:0] = afl_q;
            tvr_pkg::OFS_BLT_NUM: rmux[7:0] = blt_num_q;
            tvr_pkg::OFS_FW_REV: rmux[7:0] = tvr_pkg::FW_REVISION;
            tvr_pkg::OFS_TEST_WORD: rmux = test_word_q;
            tvr_pkg::OFS_OUT_SEL: rmux[2:0] = out_sel_q;
            default: rmux = 32'h0000_0000;
        endcase
    end

    wire logic [15:0] wv = req.wdata[15:0];
    wire logic [15:0] afl_d = (wv < tvr_pkg::AFL_MIN) ? tvr_pkg::AFL_MIN
                            : (wv > tvr_pkg::AFL_MAX) ? tvr_pkg::AFL_MAX
                            : wv;

    wire logic [15:0] base_d = reloc_q ? {rhi_q, rlo_q} : switch_base;

    // bus answer; vector on acknowledge
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc | iack;
            if (iack)
                rdata_q <= {24'h000000, vec_q};
            else if (req.rd)
                rdata_q <= rmux;
        end
    end

    // one-shot pulses
    always_ff @(posedge clk) begin
        if (reset) begin
            module_reset_q <= 1'b0;
        end else begin
            module_reset_q <= a_rst & ~module_reset_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst)
            clear_q <= 1'b0;
        else
            clear_q <= w_clr;
    end

    always_ff @(posedge clk) begin
        if (srst)
            event_reset_q <= 1'b0;
        else
            event_reset_q <= w_evr;
    end

    always_ff @(posedge clk) begin
        if (srst)
            trigger_q <= 1'b0;
        else
            trigger_q <= w_trg;
    end

    always_ff @(posedge clk) begin
        if (srst)
            test_push_q <= 1'b0;
        else
            test_push_q <= w_tst & test_mode;
    end

    // block converter data in test mode
    always_ff @(posedge clk) begin
        if (reset) begin
            tdc_block_q <= 1'b0;
            test_word_q <= 32'h0000_0000;
        end else begin
            tdc_block_q <= test_mode;
            if (w_tst)
                test_word_q <= req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst)
            rhi_q <= 8'h00;
        else if (w_rhi)
            rhi_q <= req.wdata[7:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            rlo_q <= 8'h00;
        else if (w_rlo)
            rlo_q <= req.wdata[7:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            reloc_q <= 1'b0;
        else if (w_ren)
            reloc_q <= req.wdata[0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            base_addr_q <= 16'h0000;
        else
            base_addr_q <= base_d;
    end

    always_ff @(posedge clk) begin
        if (srst)
            irq_level_q <= tvr_pkg::RST_IRQ_LEVEL;
        else if (w_lvl)
            irq_level_q <= req.wdata[2:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            vec_q <= tvr_pkg::RST_IRQ_VECTOR;
        else if (w_vec)
            vec_q <= req.wdata[7:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            slot_q <= tvr_pkg::RST_SLOT;
        else if (w_slot)
            slot_q <= req.wdata[4:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            bcast_base_q <= tvr_pkg::RST_BCAST_BASE;
        else if (w_bb)
            bcast_base_q <= req.wdata[7:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            bcast_ctl_q <= 2'h0;
        else if (w_bc)
            bcast_ctl_q <= req.wdata[1:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            afl_q <= tvr_pkg::RST_AFL;
        else if (w_afl)
            afl_q <= afl_d;
    end

    always_ff @(posedge clk) begin
        if (srst)
            blt_num_q <= tvr_pkg::RST_BLT_NUM;
        else if (w_blt)
            blt_num_q <= req.wdata[7:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            out_sel_q <= 3'h0;
        else if (w_out)
            out_sel_q <= req.wdata[2:0];
    end

    always_ff @(posedge clk) begin
        if (srst)
            irq_req_q <= 1'b0;
        else
            irq_req_q <= almost & (irq_level_q != 3'h0);
    end

    genvar g;
    generate
        for (g = 0; g < N_ERR; g = g + 1) begin : g_err
            always_ff @(posedge clk) begin
                if (srst)
                    err_q[g] <= 1'b0;
                else if (acq.tdc_err[g])
                    err_q[g] <= 1'b1;
                else if (clear_q)
                    err_q[g] <= 1'b0;
            end
        end
    endgenerate

    // flags cleared by status read; a new event wins
    always_ff @(posedge clk) begin
        if (srst) begin
            berr_q <= 1'b0;
            tlost_q <= 1'b0;
        end else begin
            berr_q <= bus_fault | (berr_q & ~r_st);
            tlost_q <= trigger_dropped | (tlost_q & ~r_st);
        end
    end

    always_ff @(posedge clk) begin
        if (srst)
            sent_q <= 1'b0;
        else if (chain_sent_all)
            sent_q <= 1'b1;
        else if (chain_end)
            sent_q <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (srst | clear_q)
            evcnt_q <= 32'h0000_0000;
        else if (trig_any & mode)
            evcnt_q <= evcnt_q + 32'h0000_0001;
    end

    always_ff @(posedge clk) begin
        if (srst | clear_q)
            evst_q <= 16'h0000;
        else if (event_in & ~event_out)
            evst_q <= evst_q + 16'h0001;
        else if (event_out & ~event_in & (evst_q != 16'h0000))
            evst_q <= evst_q - 16'h0001;
    end
endmodule

// File: tb/tvr_reg_bank_assertions.sv
`timescale 1ns/100ps
module tvr_reg_bank_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // access port
    input wire tvr_pkg::tvr_req_t req,
    input wire logic iack,
    input wire logic [31:0] rdata_q,
    // acquisition side
    input wire logic [15:0] buf_words,
    input wire logic bus_fault,
    input wire logic trigger_dropped,
    input wire logic test_mode,
    // controls
    input wire logic [2:0] irq_level_q,
    input wire logic irq_req_q,
    input wire logic [15:0] afl_q,
    input wire logic module_reset_q,
    input wire logic clear_q,
    input wire logic trigger_q,
    input wire logic test_push_q,
    input wire logic [31:0] test_word_q,
    input wire logic tdc_block_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire wr_on = req.wr && !iack;
    wire rd_st = req.rd && !iack && req.addr == tvr_pkg::OFS_STATUS;
    wire flt = bus_fault || trigger_dropped;
    wire af = buf_words >= afl_q && !module_reset_q;
    sequence s_two_clean_reads;
        (rd_st && !flt) ##1 (!flt)[*2] ##1 (rd_st && !flt);
    endsequence
    chk_clear_pulse: assert property (
        wr_on && req.addr == tvr_pkg::OFS_SW_CLEAR |=> clear_q)
        else $error("clear pulse missing");
    chk_soft_trigger: assert property (
        wr_on && req.addr == tvr_pkg::OFS_SW_TRIG |=> trigger_q)
        else $error("trigger pulse missing");
    chk_module_reset: assert property (
        (req.rd || req.wr) && req.addr == tvr_pkg::OFS_MOD_RESET
        |=> module_reset_q) else $error("module reset missing");
    chk_irq_request: assert property (
        af && irq_level_q != 3'h0 |-> ##[1:2] irq_req_q)
        else $error("irq request missing");
    chk_level_zero_quiet: assert property (
        (irq_level_q == 3'h0)[*2] |=> !irq_req_q)
        else $error("irq with level zero");
    chk_almost_status: assert property (
        rd_st && af |=> rdata_q[tvr_pkg::ST_ALMOST])
        else $error("almost full bit low");
    chk_full_status: assert property (
        rd_st && buf_words >= tvr_pkg::FULL_LEVEL
        |=> rdata_q[tvr_pkg::ST_FULL]) else $error("full bit low");
    chk_test_push: assert property (
        test_mode && wr_on && req.addr == tvr_pkg::OFS_TEST_WORD
        |=> test_push_q && test_word_q == $past(req.wdata))
        else $error("test word not pushed");
    chk_flags_read_clear: assert property (
        s_two_clean_reads |=> !rdata_q[tvr_pkg::ST_BERR]
        && !rdata_q[tvr_pkg::ST_TLOST]) else $error("flag not cleared");
    chk_block_follows: assert property (
        test_mode |=> tdc_block_q) else $error("converter data not blocked");
endmodule
bind tvr_reg_bank tvr_reg_bank_assertions chk_i (.clk(clk),
    .reset(reset), .req(req), .iack(iack), .rdata_q(rdata_q),
    .buf_words(buf_words), .bus_fault(bus_fault),
    .trigger_dropped(trigger_dropped), .test_mode(test_mode),
    .irq_level_q(irq_level_q), .irq_req_q(irq_req_q), .afl_q(afl_q),
    .module_reset_q(module_reset_q), .clear_q(clear_q),
    .trigger_q(trigger_q), .test_push_q(test_push_q),
    .test_word_q(test_word_q), .tdc_block_q(tdc_block_q));

// File: tb/tvr_host_model.sv
`timescale 1ns/100ps
module tvr_host_model (
    // clock
    input wire logic clk,
    // access port
    output tvr_pkg::tvr_req_t req,
    output logic iack,
    input wire logic ack_q,
    input wire logic [31:0] rdata_q
);
    logic [31:0] seen;
    logic tmo;
    initial begin
        req = '0;
        iack = 1'h0;
        seen = '0;
        tmo = 1'h0;
    end
    // strobe lasts one cycle; a longer one would be a second access
    task automatic xfer(input logic r, input logic w, input logic i,
                        input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{rd: r, wr: w, addr: a, wdata: d};
        iack <= i;
        @(posedge clk);
        req.rd <= 1'h0;
        req.wr <= 1'h0;
        iack <= 1'h0;
        for (int n = 0; n < 4; n++) begin
            @(posedge clk);
            if (ack_q === 1'h1) begin
                seen = rdata_q;
                return;
            end
        end
        tmo = 1'h1;
    endtask
endmodule

// File: tb/tvr_reg_bank_tb_top.sv
`timescale 1ns/100ps
module tvr_reg_bank_tb_top;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic test_mode = 1'h0;
    logic [6:0] pl = '0;
    logic [15:0] sw_base = 16'h5a00;
    logic [15:0] buf_words = '0;
    tvr_pkg::tvr_acq_t acq = '0;
    tvr_pkg::tvr_req_t req;
    logic iack, ack_q, irq_req_q, tdc_block_q;
    logic [31:0] rdata_q, test_word_q;
    logic [15:0] base_addr_q;
    int fails = 0;
    int n_compared = 0;
    logic [31:0] rst_tab [6] = '{32'h100a0000, 32'h100c00dd,
        32'h100e001f, 32'h101000aa, 32'h10220040, 32'h10240000};
    logic [47:0] wr_tab [9] = '{48'h100afffd0005, 48'h100c12340034,
        48'h100e00030003, 48'h102200000001, 48'h10227fff7fdf,
        48'h102401ff00ff, 48'h101012550055, 48'h101200070003,
        48'h102cfffa0002};
    initial forever #20 clk = ~clk;
    tvr_host_model host (.clk(clk), .req(req), .iack(iack),
        .ack_q(ack_q), .rdata_q(rdata_q));
    tvr_reg_bank dut (.clk(clk), .reset(reset), .req(req), .iack(iack),
        .ack_q(ack_q), .rdata_q(rdata_q), .acq(acq),
        .buf_words(buf_words), .event_in(pl[0]), .event_out(pl[1]),
        .ext_trigger(pl[2]), .trigger_dropped(pl[3]), .bus_fault(pl[4]),
        .chain_sent_all(pl[5]), .chain_end(pl[6]), .test_mode(test_mode),
        .switch_base(sw_base), .base_addr_q(base_addr_q),
        .irq_level_q(), .irq_req_q(irq_req_q), .slot_q(),
        .bcast_base_q(), .bcast_ctl_q(), .afl_q(), .blt_num_q(),
        .out_sel_q(), .module_reset_q(), .clear_q(), .event_reset_q(),
        .trigger_q(), .test_push_q(), .test_word_q(test_word_q),
        .tdc_block_q(tdc_block_q));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic acc(input logic r, input logic w, input logic i,
                       input logic [15:0] a, input logic [31:0] d);
        host.xfer(r, w, i, a, d);
        if (host.tmo) begin
            fails++;
            summarize();
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        acc(1'h0, 1'h1, 1'h0, a, d);
    endtask
    task automatic rdm(input logic [15:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        acc(1'h1, 1'h0, 1'h0, a, 32'h0);
        check(host.seen & m, e);
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        pl[b] <= 1'h1;
        @(posedge clk);
        pl[b] <= 1'h0;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        foreach (rst_tab[k]) begin
            rdm(rst_tab[k][31:16], '1, {16'h0, rst_tab[k][15:0]});
        end
        check(32'(base_addr_q), 32'h5a00);
        wr(16'h1004, 32'h12);
        wr(16'h1006, 32'h34);
        rdm(16'h1004, '1, 32'h12);
        wr(16'h1008, 32'h1);
        sw_base <= 16'h6600;
        repeat (2) @(posedge clk);
        check(32'(base_addr_q), 32'h1234);
        foreach (wr_tab[k]) begin
            wr(wr_tab[k][47:32], {16'h0, wr_tab[k][31:16]});
            rdm(wr_tab[k][47:32], '1, {16'h0, wr_tab[k][15:0]});
        end
        acc(1'h0, 1'h0, 1'h1, 16'h0, 32'h0);
        check(host.seen & 32'hff, 32'h34);
        rdm(16'h1008, '1, 32'h0);
        wr(16'h1022, 32'h100);
        buf_words <= 16'h00ff;
        rdm(16'h1002, 32'h803, 32'h1);
        buf_words <= 16'h0100;
        rdm(16'h1002, 32'h2, 32'h2);
        repeat (2) @(posedge clk);
        check(32'(irq_req_q), 32'h1);
        wr(16'h100a, 32'h0);
        repeat (3) @(posedge clk);
        check(32'(irq_req_q), 32'h0);
        buf_words <= 16'h0;
        rdm(16'h1002, 32'h801, 32'h800);
        acq <= 10'h3a0;
        buf_words <= 16'h7fdf;
        rdm(16'h1002, 32'h703f, 32'h601e);
        buf_words <= 16'h7fde;
        rdm(16'h1002, 32'h4, 32'h0);
        pulse(5);
        rdm(16'h1002, 32'h800, 32'h800);
        pulse(6);
        rdm(16'h1002, 32'h800, 32'h0);
        pulse(0);
        rdm(16'h1002, 32'h1, 32'h1);
        pulse(0);
        pulse(1);
        rdm(16'h1020, '1, 32'h1);
        acq.tdc_err <= 4'h2;
        @(posedge clk);
        acq.tdc_err <= 4'h0;
        rdm(16'h1002, 32'h3c0, 32'h80);
        pulse(4);
        pulse(3);
        rdm(16'h1002, 32'h8400, 32'h8400);
        rdm(16'h1002, 32'h8400, 32'h0);
        pulse(2);
        wr(16'h101a, 32'h0);
        rdm(16'h101c, '1, 32'h2);
        acq <= 10'h0;
        pulse(2);
        rdm(16'h101c, '1, 32'h2);
        wr(16'h1016, 32'h0);
        rdm(16'h101c, '1, 32'h0);
        rdm(16'h1020, '1, 32'h0);
        rdm(16'h1002, 32'h3c0, 32'h0);
        test_mode <= 1'h1;
        wr(16'h1028, 32'hcafe0001);
        check(test_word_q, 32'hcafe0001);
        check(32'(tdc_block_q), 32'h1);
        rdm(16'h1028, '1, 32'hcafe0001);
        acc(1'h1, 1'h0, 1'h0, 16'h1014, 32'h0);
        rdm(16'h100c, '1, 32'hdd);
        summarize();
    end
endmodule
